// File: hw/flash_cmd.v
// Operation
// - Read streams consecutive bytes, address counter advances by itself.
// - Read opcodes 1Bh, 0Bh and 03h accepted; host respects their clock limits.
// - Opcode 1Bh takes two dummy bytes before data comes out.
// - Opcode 0Bh takes exactly one dummy byte before data.
// - Single read shifts one bit per clock on the output line, MSB first.
// - Reads wrap from top address 1FFFFFh to 000000h with no gap.
// - Chip select release ends a single read and floats the output.
// - Dual read is 3Bh, three address bytes, one dummy; host keeps clock limit.
// - Dual read drives bits 7 and 6 first, two per clock, byte per four.
// - Chip select release ends a dual read and floats both data lines.
// - Programming starts only while the write enable latch is set.
// - Program is 02h, three address bytes, then data into the page buffer.
// - Data past page end wraps to the page start, upper bits fixed.
// - More than 256 bytes sent keeps only the final 256.
// - On release only buffered bytes are programmed; others stay erased.
// - Full address, one whole byte, byte-aligned release, else abort.
// - Protected or locked start address programs nothing, returns idle.
// - Every program abort clears the write enable latch.
// - Busy during programming; latch cleared as busy drops at the cycle end.
// - A byte failing to program sets the program error flag.
// - Three address bytes taken; top three bits ignored.
// - Dual read turns the second data line into an output.
`timescale 1ns/1ps
`include "flash_defines.vh"

// ********************************
// Program data FIFO
// ********************************
module pgm_fifo #(
	parameter WIDTH = 29,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             ref_clk,
	input  wire             arst_n,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // pgm_fifo

// ********************************
// Read and page program command logic
// ********************************
module flash_cmd #(
	parameter AW = `ARRAY_ADDR_W
) (
	input  wire          ref_clk,
	input  wire          arst_n,
	input  wire          cs_n,
	input  wire          sclk,
	input  wire          si,
	output reg           so_data,
	output reg           so_oe,
	output reg           second_data_line,
	output reg           second_data_line_oe,
	output reg  [AW-1:0] array_addr,
	input  wire [7:0]    array_rdata,
	input  wire          sector_locked,
	input  wire          write_enable_set,
	output reg           write_enable_latch,
	output reg           busy,
	output reg           program_error_flag,
	output reg           pgm_valid,
	input  wire          pgm_ready,
	output reg  [AW-1:0] pgm_addr,
	output reg  [7:0]    pgm_data,
	input  wire          pgm_fail
);

	localparam ST_OPC   = 7'h01;
	localparam ST_ADDR  = 7'h02;
	localparam ST_DUMMY = 7'h04;
	localparam ST_READ  = 7'h08;
	localparam ST_PDATA = 7'h10;
	localparam ST_SKIP  = 7'h20;
	localparam ST_PROG  = 7'h40;
	localparam FW       = AW + 8;

	reg  [6:0]    state;
	reg           sclk_q;
	reg           cs_q;
	reg  [2:0]    bit_cnt;
	reg  [6:0]    shift_in;
	reg  [1:0]    byte_cnt;
	reg  [1:0]    dummy_left;
	reg           is_prog;
	reg           dual;
	reg  [2:0]    out_cnt;
	reg  [7:0]    out_shift;
	reg  [7:0]    page_buf [0:255];
	reg  [7:0]    buf_off;
	reg  [8:0]    buf_count;
	reg  [7:0]    it_off;
	reg  [8:0]    it_left;
	wire          sck_rise;
	wire          sck_fall;
	wire          cs_release;
	wire          byte_done;
	wire [7:0]    new_byte;
	wire [7:0]    out_byte;
	wire [2:0]    out_last;
	wire          fifo_in_ready;
	wire          fifo_out_valid;
	wire [FW-1:0] fifo_out_data;
	wire          fifo_pop;
	wire          fifo_push;

	assign sck_rise   = sclk & ~sclk_q & ~cs_n;
	assign sck_fall   = ~sclk & sclk_q & ~cs_n;
	assign cs_release = cs_n & ~cs_q;
	assign byte_done  = sck_rise & (bit_cnt == 3'h7);
	assign new_byte   = {shift_in, si};
	assign out_byte   = (out_cnt == 3'h0) ? array_rdata : out_shift;
	assign out_last   = dual ? `BIT_LAST_DUAL : `BIT_LAST_SINGLE;
	assign fifo_push  = (state == ST_PROG) & (it_left != 9'h000);
	assign fifo_pop   = fifo_out_valid & (~pgm_valid | pgm_ready);

	// ********************************
	// Page buffer
	// ********************************
	always @(posedge ref_clk) begin
		if (state == ST_PDATA && byte_done) begin
			page_buf[buf_off] <= new_byte;
		end
	end

	pgm_fifo #(
		.WIDTH (FW),
		.DEPTH (`PGM_FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   ({array_addr[AW-1:8], it_off, page_buf[it_off]}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// ********************************
	// Command sequencer
	// ********************************
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state              <= ST_OPC;
			sclk_q             <= 1'b0;
			cs_q               <= 1'b1;
			bit_cnt            <= 3'h0;
			shift_in           <= 7'h00;
			byte_cnt           <= 2'h0;
			dummy_left         <= 2'h0;
			is_prog            <= 1'b0;
			dual               <= 1'b0;
			out_cnt            <= 3'h0;
			out_shift          <= 8'h00;
			so_data            <= 1'b0;
			so_oe              <= 1'b0;
			second_data_line   <= 1'b0;
			second_data_line_oe <= 1'b0;
			array_addr         <= {AW{1'b0}};
			buf_off            <= 8'h00;
			buf_count          <= 9'h000;
			it_off             <= 8'h00;
			it_left            <= 9'h000;
			write_enable_latch <= 1'b0;
			busy               <= 1'b0;
			program_error_flag <= 1'b0;
			pgm_valid          <= 1'b0;
			pgm_addr           <= {AW{1'b0}};
			pgm_data           <= 8'h00;
		end else begin
			sclk_q <= sclk;
			cs_q   <= cs_n;
			if (write_enable_set && !busy) begin
				write_enable_latch <= 1'b1;
			end
			if (sck_rise) begin
				shift_in <= new_byte[6:0];
				bit_cnt  <= bit_cnt + 3'h1;
			end
			if (cs_n) begin
				bit_cnt             <= 3'h0;
				so_oe               <= 1'b0;
				second_data_line_oe <= 1'b0;
			end
			case (state)
				ST_OPC: begin
					if (byte_done) begin
						byte_cnt <= 2'h0;
						is_prog  <= 1'b0;
						dual     <= 1'b0;
						state    <= ST_ADDR;
						case (new_byte)
							`OPC_READ_FAST2: dummy_left <= `DUMMY_FAST2;
							`OPC_READ_FAST1: dummy_left <= `DUMMY_FAST1;
							`OPC_READ_SLOW: dummy_left <= `DUMMY_SLOW;
							`OPC_READ_DUAL: begin
								dummy_left <= `DUMMY_DUAL;
								dual       <= 1'b1;
							end
							`OPC_PAGE_PROGRAM: begin
								is_prog <= 1'b1;
								if (!write_enable_latch) begin
									state <= ST_SKIP;
								end
							end
							default: state <= ST_SKIP;
						endcase
					end
				end
				ST_ADDR: begin
					if (cs_release) begin
						if (is_prog) begin
							write_enable_latch <= 1'b0;
						end
						state <= ST_OPC;
					end else if (byte_done) begin
						array_addr <= {array_addr[AW-9:0], new_byte};
						byte_cnt   <= byte_cnt + 2'h1;
						if (byte_cnt == `ADDR_BYTES_LAST) begin
							buf_off   <= new_byte;
							buf_count <= 9'h000;
							out_cnt   <= 3'h0;
							if (is_prog) begin
								state <= ST_PDATA;
							end else if (dummy_left != 2'h0) begin
								state <= ST_DUMMY;
							end else begin
								state <= ST_READ;
							end
						end
					end
				end
				ST_DUMMY: begin
					if (cs_release) begin
						state <= ST_OPC;
					end else if (byte_done) begin
						dummy_left <= dummy_left - 2'h1;
						if (dummy_left == 2'h1) begin
							state <= ST_READ;
						end
					end
				end
				ST_READ: begin
					if (cs_release) begin
						state <= ST_OPC;
					end else if (sck_fall) begin
						so_oe               <= 1'b1;
						second_data_line_oe <= dual;
						so_data             <= out_byte[7];
						second_data_line    <= out_byte[6];
						out_shift           <= dual ? {out_byte[5:0], 2'h0} : {out_byte[6:0], 1'b0};
						out_cnt <= (out_cnt == out_last) ? 3'h0 : out_cnt + 3'h1;
						if (out_cnt == 3'h0) begin
							array_addr <= array_addr + {{(AW-1){1'b0}}, 1'b1};
						end
					end
				end
				ST_PDATA: begin
					if (cs_release) begin
						if (bit_cnt != 3'h0 || buf_count == 9'h000 || sector_locked) begin
							write_enable_latch <= 1'b0;
							state              <= ST_OPC;
						end else begin
							busy               <= 1'b1;
							program_error_flag <= 1'b0;
							it_left            <= buf_count;
							it_off             <= buf_off - buf_count[7:0];
							state              <= ST_PROG;
						end
					end else if (byte_done) begin
						buf_off <= buf_off + 8'h01;
						if (buf_count != `PAGE_BYTES) begin
							buf_count <= buf_count + 9'h001;
						end
					end
				end
				ST_SKIP: begin
					if (cs_release) begin
						state <= ST_OPC;
					end
				end
				ST_PROG: begin
					if (fifo_push && fifo_in_ready) begin
						it_off  <= it_off + 8'h01;
						it_left <= it_left - 9'h001;
					end
					if (it_left == 9'h000 && !fifo_out_valid && !pgm_valid) begin
						write_enable_latch <= 1'b0;
						busy               <= 1'b0;
						state              <= ST_OPC;
					end
				end
				default: state <= ST_OPC;
			endcase
			if (state != ST_READ && state != ST_PROG && cs_n) begin
				dual <= 1'b0;
			end
			if (fifo_pop) begin
				pgm_valid <= 1'b1;
				pgm_addr  <= fifo_out_data[FW-1:8];
				pgm_data  <= fifo_out_data[7:0];
			end else if (pgm_ready) begin
				pgm_valid <= 1'b0;
			end
			if (pgm_valid && pgm_ready && pgm_fail) begin
				program_error_flag <= 1'b1;
			end
		end
	end
endmodule // flash_cmd

// File: hw/flash_defines.vh
`ifndef FLASH_DEFINES_VH
`define FLASH_DEFINES_VH

// ********************************
// Opcodes
// ********************************
`define OPC_READ_FAST2   8'h1b
`define OPC_READ_FAST1   8'h0b
`define OPC_READ_SLOW    8'h03
`define OPC_READ_DUAL    8'h3b
`define OPC_PAGE_PROGRAM 8'h02

// ********************************
// Dummy byte counts per read opcode
// ********************************
`define DUMMY_FAST2      2'h2
`define DUMMY_FAST1      2'h1
`define DUMMY_SLOW       2'h0
`define DUMMY_DUAL       2'h1

// ********************************
// Addressing
// ********************************
`define ADDR_BYTES_LAST  2'h2
`define ARRAY_ADDR_W     21
`define PAGE_BYTES       9'h100
`define BIT_LAST_SINGLE  3'h7
`define BIT_LAST_DUAL    3'h3

// ********************************
// Program data path
// ********************************
`define PGM_FIFO_DEPTH   8

`endif

// File: sim/flash_cmd_chk_sva.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module flash_cmd_chk #(
	parameter AW = 21
) (
	input wire          ref_clk,
	input wire          arst_n,
	input wire          cs_n,
	input wire          so_oe,
	input wire          second_data_line_oe,
	input wire          busy,
	input wire          write_enable_latch,
	input wire          program_error_flag,
	input wire          pgm_valid,
	input wire          pgm_ready,
	input wire          pgm_fail,
	input wire [AW-1:0] pgm_addr,
	input wire [7:0]    pgm_data
);
	logic [AW-1:0] last_addr;

	always @(posedge ref_clk)
		if (pgm_valid && pgm_ready)
			last_addr <= pgm_addr;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	a_so_float: assert property ($rose(cs_n) |-> ##2 !so_oe)
		else $error("so still driven after release");
	a_second_line_float: assert property ($rose(cs_n) |-> ##2 !second_data_line_oe)
		else $error("second line still driven after release");
	a_dual_pair: assert property (second_data_line_oe |-> so_oe)
		else $error("second line driven alone");
	a_pgm_hold: assert property (pgm_valid && !pgm_ready |=> pgm_valid && $stable(pgm_addr) && $stable(pgm_data))
		else $error("write request changed before acceptance");
	a_pgm_busy: assert property (pgm_valid |-> busy)
		else $error("write request while not busy");
	a_wel_done: assert property ($fell(busy) |-> !write_enable_latch)
		else $error("latch still set after program");
	a_fail_flag: assert property (pgm_valid && pgm_ready && pgm_fail |-> ##[1:2] program_error_flag)
		else $error("failed byte not flagged");
	a_page_fixed: assert property ((pgm_valid && pgm_ready ##1 pgm_valid) |-> pgm_addr[AW-1:8] == last_addr[AW-1:8])
		else $error("page bits changed within a program");
endmodule // flash_cmd_chk

bind flash_cmd flash_cmd_chk #(.AW(AW)) u_flash_cmd_chk (
	.ref_clk, .arst_n, .cs_n, .so_oe, .second_data_line_oe, .busy, .write_enable_latch, .program_error_flag,
	.pgm_valid, .pgm_ready, .pgm_fail, .pgm_addr, .pgm_data
);

// File: sim/flash_cmd_tb_top.sv
`timescale 1ns/1ps
module flash_cmd_tb_top;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        cs_n, sclk, si, so_data, so_oe, second_data_line, second_data_line_oe;
	logic        write_enable_latch, busy, program_error_flag, pgm_valid;
	logic        sector_locked = 1'b0;
	logic        write_enable_set = 1'b0;
	logic        pgm_ready = 1'b0;
	logic        pgm_fail = 1'b0;
	logic [20:0] array_addr, pgm_addr;
	logic [7:0]  array_rdata, pgm_data;
	logic [7:0]  wr [logic [20:0]];
	int          error_cnt, num_checks;

	// ****
	// Array model
	// ****
	always #10 ref_clk = ~ref_clk;
	assign array_rdata = array_addr[7:0] ^ 8'ha5;
	// Write port stalls every other cycle; byte 3dh fails
	always @(negedge ref_clk) begin
		pgm_ready <= ~pgm_ready;
		pgm_fail  <= (pgm_data == 8'h3d);
	end
	always @(posedge ref_clk)
		if (pgm_valid && pgm_ready)
			wr[pgm_addr] = pgm_data;

	flash_cmd u_flash_cmd (
		.ref_clk, .arst_n, .cs_n, .sclk, .si, .so_data, .so_oe, .second_data_line, .second_data_line_oe,
		.array_addr, .array_rdata, .sector_locked, .write_enable_set, .write_enable_latch,
		.busy, .program_error_flag, .pgm_valid, .pgm_ready, .pgm_addr, .pgm_data, .pgm_fail
	);
	spi_host u_spi_host (
		.ref_clk, .so_data, .so_oe, .second_data_line, .second_data_line_oe, .cs_n, .sclk, .si
	);

	// ****
	// Helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic head(input logic [7:0] op, input logic [23:0] a, input int nd);
		u_spi_host.frame_on();
		u_spi_host.send(op);
		for (int i = 2; i >= 0; i--)
			u_spi_host.send(a[8*i +: 8]);
		repeat (nd) u_spi_host.send(8'h00);
	endtask
	// poll busy instead of a fixed wait
	task automatic wait_idle;
		for (int i = 0; busy !== 1'b0; i++) begin
			if (i > 5000) begin
				error_cnt++;
				give_verdict();
			end
			@(negedge ref_clk);
		end
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_read;
		logic [7:0] ops [4] = '{8'h03, 8'h0b, 8'h1b, 8'h3b};
		int         nd [4] = '{0, 1, 2, 1};
		logic [7:0] r;
		logic       q, q2;
		for (int k = 0; k < 4; k++) begin
			head(ops[k], 24'hfffffe, nd[k]);
			for (int j = 0; j < 3; j++) begin
				for (int b = 0; b < ((k == 3) ? 4 : 8); b++) begin
					u_spi_host.clk_bit(1'b0, q, q2);
					r = (k == 3) ? {r[5:0], q, q2} : {r[6:0], q};
				end
				chk(r, 8'(8'hfe + j) ^ 8'ha5);
			end
			chk(second_data_line_oe, k == 3);
			u_spi_host.clk_bit(1'b0, q, q2);
			u_spi_host.frame_off();
			chk({so_oe, second_data_line_oe}, 2'b00);
		end
		$display("read test done");
	endtask
	task automatic t_prog(input logic [23:0] a, input int n, input logic lock, input int tail, input logic we);
		logic [7:0] ex [logic [20:0]];
		logic       q, q2, ok;
		ok = we && !lock && n > 0 && tail == 0;
		wr.delete();
		@(negedge ref_clk);
		write_enable_set = we;
		@(negedge ref_clk);
		write_enable_set = 1'b0;
		sector_locked = lock;
		chk(write_enable_latch, we);
		head(8'h02, a, 0);
		for (int i = 0; i < n; i++) begin
			u_spi_host.send(8'(i) ^ 8'h3c);
			ex[{a[20:8], 8'(a[7:0] + i)}] = 8'(i) ^ 8'h3c;
		end
		repeat (tail) u_spi_host.clk_bit(1'b1, q, q2);
		u_spi_host.frame_off();
		chk(busy, ok);
		wait_idle();
		if (!ok)
			ex.delete();
		chk(wr.num(), ex.num());
		foreach (ex[k])
			chk(wr.exists(k) ? wr[k] : 9'h100, ex[k]);
		chk(write_enable_latch, 1'b0);
		if (ok)
			chk(program_error_flag, n > 1);
		$display("program test n=%0d done", n);
	endtask

	initial begin
		repeat (2) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		t_read();
		t_prog(24'hab12fe, 3, 1'b0, 0, 1'b1);
		t_prog(24'h001234, 258, 1'b0, 0, 1'b1);
		t_prog(24'h000010, 1, 1'b0, 0, 1'b1);
		t_prog(24'h000010, 0, 1'b0, 0, 1'b1);
		t_prog(24'h000010, 1, 1'b0, 4, 1'b1);
		t_prog(24'h000010, 1, 1'b0, 0, 1'b0);
		t_prog(24'h000010, 1, 1'b1, 0, 1'b1);
		give_verdict();
	end
endmodule // flash_cmd_tb_top

// File: sim/spi_host.sv
`timescale 1ns/1ps
// ****
// Host side of the serial link
// ****
module spi_host (
	input  wire  ref_clk,
	input  wire  so_data,
	input  wire  so_oe,
	input  wire  second_data_line,
	input  wire  second_data_line_oe,
	output logic cs_n,
	output logic sclk,
	output logic si
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si   = 1'b0;
	end
	// slow clock keeps every opcode in its limit
	task automatic clk_bit(input logic b, output logic q, output logic q2);
		@(negedge ref_clk);
		sclk = 1'b0;
		si   = b;
		repeat (4) @(negedge ref_clk);
		// A floating line reads back inverted, so a missing enable garbles the data
		q    = so_oe ? so_data : ~so_data;
		q2   = second_data_line_oe ? second_data_line : ~second_data_line;
		sclk = 1'b1;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic send(input logic [7:0] v);
		logic q, q2;
		for (int i = 7; i >= 0; i--)
			clk_bit(v[i], q, q2);
	endtask
	task automatic frame_on;
		@(negedge ref_clk);
		cs_n = 1'b0;
	endtask
	// release falls after whole clocks; data line stops holding
	task automatic frame_off;
		@(negedge ref_clk);
		cs_n = 1'b1;
		sclk = 1'b0;
		si   = ~si;
		repeat (2) @(negedge ref_clk);
	endtask
endmodule // spi_host
